// ==== bench/sdt_timer_sva.sv ====
`timescale 1ns/1ps
module sdt_timer_sva
	import sdt_pkg::*;
#(
	parameter int CHANNELS = 3
)
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	input wire logic [2*CHANNELS-1:0] waveform_out_pin,
	input wire logic [2*CHANNELS-1:0] waveform_out_oe,
	input wire logic [CHANNELS-1:0] low_compare_irq,
	input wire logic high_underflow_irq,
	input wire logic low_underflow_irq
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	////////////////////////////////////////////////////////////////
	logic wr_q, rd_q, en_q;
	logic [5:0] idx_q;
	logic [7:0] ce_q, ov_q, ie_q;
	wire logic take = hsel && htrans[1] && hready;
	wire logic wr_done = wr_q && hready;
	wire logic cmd_port = idx_q == SDT_IDX_CMD_CLR || idx_q == SDT_IDX_CMD_SET;
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
		begin
			wr_q <= 1'b0;
			rd_q <= 1'b0;
			idx_q <= 6'h00;
		end
		else if (hready)
		begin
			wr_q <= take && hwrite;
			rd_q <= take && !hwrite;
			idx_q <= haddr[7:2];
		end
	// shadow of the registers whose effect shows at the pins; a hard reset wipes them too
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
		begin
			en_q <= 1'b0;
			ce_q <= 8'h00;
			ov_q <= 8'h00;
			ie_q <= 8'h00;
		end
		else if (wr_done && cmd_port && hwdata[3:2] == 2'h3 && !en_q)
		begin
			en_q <= 1'b0;
			ce_q <= 8'h00;
			ov_q <= 8'h00;
			ie_q <= 8'h00;
		end
		else if (wr_done)
		begin
			if (idx_q == SDT_IDX_RUN_CTL) en_q <= hwdata[0];
			if (idx_q == SDT_IDX_OUT_EN) ce_q <= hwdata[7:0];
			if (idx_q == SDT_IDX_OUT_VALUE) ov_q <= hwdata[7:0];
			if (idx_q == SDT_IDX_IRQ_EN) ie_q <= hwdata[7:0];
		end
	////////////////////////////////////////////////////////////////
	a_idle_pins: assert property (
		!en_q && !$past(en_q) && $stable(ov_q) |-> waveform_out_pin == {ov_q[6:4], ov_q[2:0]})
		else $error("idle pins differ from idle values");
	a_oe_copy: assert property (
		waveform_out_oe == {$past(ce_q[6:4]), $past(ce_q[2:0])})
		else $error("output enables do not follow compare enables");
	a_cmp_mask: assert property ((low_compare_irq & ~ie_q[6:4]) == 3'h0)
		else $error("compare request without its enable");
	a_high_unf_mask: assert property (high_underflow_irq |-> ie_q[1])
		else $error("high underflow request without enable");
	a_low_unf_mask: assert property (low_underflow_irq |-> ie_q[0])
		else $error("low underflow request without enable");
	a_cmp_hold: assert property (
		(|low_compare_irq) && !wr_done |=>
		(low_compare_irq & $past(low_compare_irq)) == $past(low_compare_irq))
		else $error("compare request dropped without software clear");
	a_high_unf_hold: assert property (high_underflow_irq && !wr_done |=> high_underflow_irq)
		else $error("high underflow dropped without software clear");
	a_low_unf_hold: assert property (low_underflow_irq && !wr_done |=> low_underflow_irq)
		else $error("low underflow dropped without software clear");
	a_cmd_read_zero: assert property (rd_q && hready && cmd_port |-> hrdata[3:2] == 2'h0)
		else $error("command field read back nonzero");
	a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read data phase not one wait state");
	a_resp_okay: assert property (hresp == 1'b0)
		else $error("response not okay");
endmodule // sdt_timer_sva

bind sdt_timer sdt_timer_sva #(.CHANNELS(CHANNELS)) u_sva (.hclk(hclk), .hresetn(hresetn),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
	.hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
	.waveform_out_pin(waveform_out_pin), .waveform_out_oe(waveform_out_oe),
	.low_compare_irq(low_compare_irq), .high_underflow_irq(high_underflow_irq),
	.low_underflow_irq(low_underflow_irq));

// ==== bench/sdt_timer_tb.sv ====
`timescale 1ns/1ps
module sdt_timer_tb
	import sdt_pkg::*;
;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic cpu_halted = 1'b0;
	logic hready, hreadyout, hresp, hirq, lirq;
	logic [31:0] hrdata, rd;
	logic [5:0] pin, oe;
	logic [2:0] cirq;
	logic [7:0] v, ov;
	logic [1:0] c;
	int bad_count = 0;
	int comparisons = 0;
	int model [int];
	logic [5:0] rw_idx [11] = '{6'h01, 6'h02, 6'h03, 6'h0a, 6'h0e, 6'h26, 6'h27, 6'h28, 6'h2a,
		6'h2b, 6'h06};
	logic [7:0] rw_mask [11] = '{8'h77, 8'h77, 8'h01, 8'h73, 8'h01, 8'hff, 8'hff, 8'hff, 8'hff,
		8'hff, 8'h00};
	logic [5:0] ro_idx [6] = '{6'h00, 6'h04, 6'h05, 6'h0b, 6'h20, 6'h21};
	always #5 hclk = ~hclk;
	assign hready = hreadyout;
	sdt_timer DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cpu_halted(cpu_halted),
		.waveform_out_pin(pin), .waveform_out_oe(oe), .low_compare_irq(cirq),
		.high_underflow_irq(hirq), .low_underflow_irq(lirq));
	////////////////////////////////////////////////////////////////
	task automatic results();
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// ready is looked at mid-cycle, where it already holds its value for the coming edge
	task automatic wait_rdy(output logic [31:0] d);
		int n;
		n = 0;
		@(negedge hclk);
		while (hready !== 1'b1 && n < 100)
		begin
			@(negedge hclk);
			n++;
		end
		d = hrdata;
		if (n >= 100)
		begin
			bad_count++;
			results();
		end
		@(posedge hclk);
	endtask
	task automatic xfer(input logic [5:0] idx, input logic wr_n, input logic [7:0] wd,
		output logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, idx, 2'h0};
		htrans <= 2'h2;
		hwrite <= wr_n;
		wait_rdy(d);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, wd};
		wait_rdy(d);
	endtask
	task automatic wr(input logic [5:0] idx, input logic [7:0] wd);
		logic [31:0] d;
		xfer(idx, 1'b1, wd, d);
	endtask
	task automatic put(input logic [5:0] idx, input logic [7:0] wd);
		wr(idx, wd);
		model[idx] = wd;
	endtask
	task automatic rdchk(input logic [5:0] idx, input logic [7:0] e);
		logic [31:0] d;
		xfer(idx, 1'b0, 8'h00, d);
		check(d, {24'h0, e});
	endtask
	////////////////////////////////////////////////////////////////
	initial
	begin
		v = $urandom(32'hfe0181bf);
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		foreach (rw_idx[i]) rdchk(rw_idx[i], 8'h00);
		foreach (ro_idx[i]) rdchk(ro_idx[i], 8'h00);
		$display("reset values done");
		foreach (rw_idx[i])
		begin
			v = $urandom();
			wr(rw_idx[i], (v & rw_mask[i]) | {8{rw_mask[i] == 8'h00}});
			model[rw_idx[i]] = v & rw_mask[i];
		end
		foreach (rw_idx[i]) rdchk(rw_idx[i], model[rw_idx[i]]);
		ov = model[2];
		repeat (2) @(posedge hclk);
		check({26'h0, pin}, {26'h0, ov[6:4], ov[2:0]});
		$display("register access done");
		wr(SDT_IDX_CMD_SET, 8'h03);
		rdchk(SDT_IDX_CMD_CLR, 8'h03);
		wr(SDT_IDX_CMD_CLR, 8'h02);
		rdchk(SDT_IDX_CMD_SET, 8'h01);
		wr(SDT_IDX_CMD_SET, 8'h06);
		rdchk(SDT_IDX_CMD_CLR, 8'h03);
		wr(SDT_IDX_CMD_CLR, 8'h03);
		rdchk(SDT_IDX_CMD_SET, 8'h00);
		$display("status ports done");
		// split off keeps the counters still, so each command shows alone
		for (int k = 0; k < 5; k++)
		begin
			c = (k > 3) ? 2'h3 : 2'(k);
			put(SDT_IDX_SPLIT_SEL, 8'h00);
			put(SDT_IDX_LOW_TOP, 8'h22);
			wr(SDT_IDX_LOW_CNT, 8'h11);
			wr(SDT_IDX_RUN_CTL, {7'h0, k == 3});
			wr(k[0] ? SDT_IDX_CMD_SET : SDT_IDX_CMD_CLR, {4'h0, c, 2'h0});
			wr(SDT_IDX_RUN_CTL, 8'h00);
			rdchk(SDT_IDX_LOW_CNT, c == 2'h2 ? 8'h22 : (k == 4 ? 8'h00 : 8'h11));
			rdchk(SDT_IDX_LOW_TOP, k == 4 ? 8'h00 : 8'h22);
		end
		foreach (model[i]) model[i] = 0;
		$display("commands done");
		put(SDT_IDX_LOW_TOP, 8'h04);
		put(SDT_IDX_HIGH_TOP, 8'h03);
		put(SDT_IDX_LOW_CMP0, 8'h02);
		put(SDT_IDX_LOW_CMP0 + SDT_IDX_CMP_STEP, 8'hff);
		put(SDT_IDX_LOW_CMP0 + 2 * SDT_IDX_CMP_STEP, 8'h03);
		put(SDT_IDX_IRQ_EN, 8'h12);
		for (int p = 0; p < 3; p++)
		begin
			put(SDT_IDX_SPLIT_SEL, {7'h0, p > 0});
			put(SDT_IDX_DBG, {7'h0, p > 1});
			cpu_halted <= (p > 0);
			wr(SDT_IDX_LOW_CNT, 8'h04);
			wr(SDT_IDX_RUN_CTL, 8'h01);
			repeat (20) @(posedge hclk);
			wr(SDT_IDX_RUN_CTL, 8'h00);
			if (p < 2) rdchk(SDT_IDX_LOW_CNT, 8'h04);
			rdchk(SDT_IDX_IRQ_FLAGS, p > 1 ? 8'h53 : 8'h00);
		end
		check({27'h0, cirq, hirq, lirq}, 32'h00000006);
		wr(SDT_IDX_IRQ_FLAGS, 8'h41);
		rdchk(SDT_IDX_IRQ_FLAGS, 8'h12);
		$display("counting done");
		// restart empties the prescaler, so at the slowest rate no tick lands before the read
		wr(SDT_IDX_CMD_SET, 8'h08);
		wr(SDT_IDX_RUN_CTL, 8'h0f);
		wr(SDT_IDX_LOW_CNT, 8'h40);
		rdchk(SDT_IDX_LOW_CNT, 8'h40);
		wr(SDT_IDX_RUN_CTL, 8'h00);
		$display("counter write done");
		results();
	end
endmodule // sdt_timer_tb

// ==== hdl/sdt_byte_timer.sv ====
`timescale 1ns/1ps
module sdt_byte_timer
	import sdt_pkg::*;
#(
	parameter int WIDTH = 8,
	parameter int CHANNELS = 3
)
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic clear,
	input wire logic restart,
	input wire logic tick,
	input wire logic wr_en,
	input wire logic [WIDTH-1:0] wr_data,
	input wire logic [WIDTH-1:0] top,
	input wire logic [CHANNELS*WIDTH-1:0] cmp,
	output logic [WIDTH-1:0] cnt,
	output logic underflow,
	output logic [CHANNELS-1:0] match
);

	logic [WIDTH-1:0] cnt_q;
	logic [WIDTH-1:0] cnt_d;
	logic advance;
	logic underflow_q;
	logic [CHANNELS-1:0] match_q;

	// a bus write beats every other source in the same cycle
	assign advance = tick && !wr_en && !clear && !restart;

	always_comb
	begin
		cnt_d = cnt_q;
		if (wr_en)
			cnt_d = wr_data;
		else if (clear)
			cnt_d = '0;
		else if (restart)
			cnt_d = top;
		else if (tick)
		begin
			if (cnt_q == '0)
				cnt_d = top;
			else
				cnt_d = cnt_q - WIDTH'(1);
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			cnt_q <= '0;
		else
			cnt_q <= cnt_d;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			underflow_q <= 1'b0;
		else
			underflow_q <= advance && (cnt_q == '0);
	end

	// match is judged on the value the counter steps to, so one hit per visit
	genvar i;
	generate
		for (i = 0; i < CHANNELS; i++)
		begin : g_cmp
			always_ff @(posedge hclk or negedge hresetn)
			begin
				if (!hresetn)
					match_q[i] <= 1'b0;
				else
					match_q[i] <= advance && (cnt_d == cmp[i*WIDTH +: WIDTH]);
			end
		end
	endgenerate

	assign cnt = cnt_q;
	assign underflow = underflow_q;
	assign match = match_q;

endmodule // sdt_byte_timer

// ==== hdl/sdt_timer.sv ====
// Our own choice: register access over AHB-Lite.
`timescale 1ns/1ps
module sdt_timer
	import sdt_pkg::*;
#(
	parameter int CHANNELS = 3
)
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic cpu_halted,
	output logic [2*CHANNELS-1:0] waveform_out_pin,
	output logic [2*CHANNELS-1:0] waveform_out_oe,
	output logic [CHANNELS-1:0] low_compare_irq,
	output logic high_underflow_irq,
	output logic low_underflow_irq
);

	////////////////////////////////////////////////////////////////////////
	// bus slave: writes take no wait state, reads take one

	logic wr_pend_q;
	logic rd_wait_q;
	logic [5:0] acc_idx_q;
	logic take;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic [31:0] hrdata_q;

	assign take = hsel && htrans[1] && hready;
	assign wdata = hwdata[7:0];

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_q <= 1'b0;
			rd_wait_q <= 1'b0;
			acc_idx_q <= 6'h00;
		end
		else
		begin
			wr_pend_q <= take && hwrite;
			rd_wait_q <= take && !hwrite;
			if (take)
				acc_idx_q <= haddr[7:2];
		end
	end

	// read data is sampled in the wait state, after any earlier write landed
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata_q <= 32'h00000000;
		else if (rd_wait_q)
			hrdata_q <= {24'h000000, rdata};
	end

	assign hreadyout = !rd_wait_q;
	assign hresp = 1'b0;
	assign hrdata = hrdata_q;

	function automatic logic wr_hit(input logic pend, input logic [5:0] idx, input logic [5:0] at);
		wr_hit = pend && (idx == at);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// control registers

	logic [7:0] run_ctl_q;
	logic [7:0] out_en_q;
	logic [7:0] out_value_q;
	logic [7:0] split_sel_q;
	logic [7:0] status_q;
	logic [7:0] irq_en_q;
	logic [7:0] flags_q;
	logic [7:0] dbg_q;
	logic [7:0] low_top_q;
	logic [7:0] high_top_q;
	logic [7:0] low_cmp_q [CHANNELS];
	logic [7:0] high_cmp_q [CHANNELS];
	logic enabled;
	logic cmd_wr;
	logic [1:0] cmd;
	logic hard_reset;
	logic restart;

	assign enabled = run_ctl_q[SDT_RUN_ENABLE_BIT];
	assign cmd_wr = wr_hit(wr_pend_q, acc_idx_q, SDT_IDX_CMD_CLR)
		|| wr_hit(wr_pend_q, acc_idx_q, SDT_IDX_CMD_SET);
	assign cmd = cmd_wr ? wdata[SDT_CMD_LSB +: 2] : SDT_CMD_NONE;
	// update has nothing to latch here, since split mode has no buffers
	assign hard_reset = (cmd == SDT_CMD_HARD_RESET) && !enabled;
	assign restart = (cmd == SDT_CMD_RESTART);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			run_ctl_q <= SDT_RST_REG;
			out_en_q <= SDT_RST_REG;
			out_value_q <= SDT_RST_REG;
			split_sel_q <= SDT_RST_REG;
			irq_en_q <= SDT_RST_REG;
			dbg_q <= SDT_RST_REG;
		end
		else if (hard_reset)
		begin
			run_ctl_q <= SDT_RST_REG;
			out_en_q <= SDT_RST_REG;
			out_value_q <= SDT_RST_REG;
			split_sel_q <= SDT_RST_REG;
			irq_en_q <= SDT_RST_REG;
			dbg_q <= SDT_RST_REG;
		end
		else
		begin
			if (wr_hit(wr_pend_q, acc_idx_q, SDT_IDX_RUN_CTL))
				run_ctl_q <= wdata & 8'h0f;
			if (wr_hit(wr_pend_q, acc_idx_q, SDT_IDX_OUT_EN))
				out_en_q <= wdata & 8'h77;
			if (wr_hit(wr_pend_q, acc_idx_q, SDT_IDX_OUT_VALUE))
				out_value_q <= wdata & 8'h77;
			if (wr_hit(wr_pend_q, acc_idx_q, SDT_IDX_SPLIT_SEL))
				split_sel_q <= wdata & 8'h01;
			if (wr_hit(wr_pend_q, acc_idx_q, SDT_IDX_IRQ_EN))
				irq_en_q <= wdata & 8'h73;
			if (wr_hit(wr_pend_q, acc_idx_q, SDT_IDX_DBG))
				dbg_q <= wdata & 8'h01;
		end
	end

	// status bits: clear port and set port act per bit, no read-modify-write
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			status_q <= SDT_RST_REG;
		else if (hard_reset)
			status_q <= SDT_RST_REG;
		else if (wr_hit(wr_pend_q, acc_idx_q, SDT_IDX_CMD_CLR))
			status_q <= status_q & ~(wdata & SDT_STATUS_MASK);
		else if (wr_hit(wr_pend_q, acc_idx_q, SDT_IDX_CMD_SET))
			status_q <= status_q | (wdata & SDT_STATUS_MASK);
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			low_top_q <= SDT_RST_TOP;
			high_top_q <= SDT_RST_TOP;
		end
		else if (hard_reset)
		begin
			low_top_q <= SDT_RST_TOP;
			high_top_q <= SDT_RST_TOP;
		end
		else
		begin
			if (wr_hit(wr_pend_q, acc_idx_q, SDT_IDX_LOW_TOP))
				low_top_q <= wdata;
			if (wr_hit(wr_pend_q, acc_idx_q, SDT_IDX_HIGH_TOP))
				high_top_q <= wdata;
		end
	end

	genvar c;
	generate
		for (c = 0; c < CHANNELS; c++)
		begin : g_cmp_regs
			localparam logic [5:0] LOW_AT = SDT_IDX_LOW_CMP0 + 6'(c * SDT_IDX_CMP_STEP);
			localparam logic [5:0] HIGH_AT = SDT_IDX_HIGH_CMP0 + 6'(c * SDT_IDX_CMP_STEP);
			always_ff @(posedge hclk or negedge hresetn)
			begin
				if (!hresetn)
				begin
					low_cmp_q[c] <= SDT_RST_REG;
					high_cmp_q[c] <= SDT_RST_REG;
				end
				else if (hard_reset)
				begin
					low_cmp_q[c] <= SDT_RST_REG;
					high_cmp_q[c] <= SDT_RST_REG;
				end
				else
				begin
					if (wr_hit(wr_pend_q, acc_idx_q, LOW_AT))
						low_cmp_q[c] <= wdata;
					if (wr_hit(wr_pend_q, acc_idx_q, HIGH_AT))
						high_cmp_q[c] <= wdata;
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// halt input synchroniser and prescaler

	logic halt_meta_q;
	logic halt_sync_q;
	logic run_ok;
	logic [9:0] presc_q;
	logic [9:0] presc_mask;
	logic tick;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			halt_meta_q <= 1'b0;
			halt_sync_q <= 1'b0;
		end
		else
		begin
			halt_meta_q <= cpu_halted;
			halt_sync_q <= halt_meta_q;
		end
	end

	function automatic logic [9:0] div_mask(input logic [2:0] sel);
		case (sel)
			3'h0: div_mask = 10'h000;
			3'h1: div_mask = 10'h001;
			3'h2: div_mask = 10'h003;
			3'h3: div_mask = 10'h007;
			3'h4: div_mask = 10'h00f;
			3'h5: div_mask = 10'h03f;
			3'h6: div_mask = 10'h0ff;
			default: div_mask = 10'h3ff;
		endcase
	endfunction

	// only split mode is built here; with the select bit clear nothing counts
	assign run_ok = enabled && split_sel_q[SDT_SPLIT_BIT]
		&& (dbg_q[SDT_DBG_RUN_BIT] || !halt_sync_q)
		&& !status_q[SDT_STATUS_HOLD_BIT];
	assign presc_mask = div_mask(run_ctl_q[SDT_CLKSEL_LSB +: 3]);
	assign tick = run_ok && ((presc_q & presc_mask) == presc_mask);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			presc_q <= 10'h000;
		else if (restart || hard_reset || !enabled)
			presc_q <= 10'h000;
		else if (run_ok)
			presc_q <= presc_q + 10'h001;
	end

	////////////////////////////////////////////////////////////////////////
	// the two byte timers

	logic [CHANNELS*8-1:0] low_cmp_flat;
	logic [CHANNELS*8-1:0] high_cmp_flat;
	logic [7:0] low_cnt;
	logic [7:0] high_cnt;
	logic low_unf;
	logic high_unf;
	logic [CHANNELS-1:0] low_match;

	generate
		for (c = 0; c < CHANNELS; c++)
		begin : g_flat
			assign low_cmp_flat[c*8 +: 8] = low_cmp_q[c];
			assign high_cmp_flat[c*8 +: 8] = high_cmp_q[c];
		end
	endgenerate

	sdt_byte_timer #(.WIDTH(8), .CHANNELS(CHANNELS)) u_low
	(
		.hclk(hclk),
		.hresetn(hresetn),
		.clear(hard_reset),
		.restart(restart),
		.tick(tick),
		.wr_en(wr_hit(wr_pend_q, acc_idx_q, SDT_IDX_LOW_CNT)),
		.wr_data(wdata),
		.top(low_top_q),
		.cmp(low_cmp_flat),
		.cnt(low_cnt),
		.underflow(low_unf),
		.match(low_match)
	);

	sdt_byte_timer #(.WIDTH(8), .CHANNELS(CHANNELS)) u_high
	(
		.hclk(hclk),
		.hresetn(hresetn),
		.clear(hard_reset),
		.restart(restart),
		.tick(tick),
		.wr_en(wr_hit(wr_pend_q, acc_idx_q, SDT_IDX_HIGH_CNT)),
		.wr_data(wdata),
		.top(high_top_q),
		.cmp(high_cmp_flat),
		.cnt(high_cnt),
		.underflow(high_unf),
		.match()
	);

	////////////////////////////////////////////////////////////////////////
	// sticky flags: a new event wins over a clear in the same cycle

	logic [7:0] flag_set;
	logic [7:0] flag_clr;

	always_comb
	begin
		flag_set = 8'h00;
		flag_set[SDT_FLAG_LOW_UNF] = low_unf;
		flag_set[SDT_FLAG_HIGH_UNF] = high_unf;
		flag_set[SDT_FLAG_LOW_CMP_LSB +: CHANNELS] = low_match;
	end

	assign flag_clr = wr_hit(wr_pend_q, acc_idx_q, SDT_IDX_IRQ_FLAGS) ? wdata : 8'h00;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			flags_q <= SDT_RST_REG;
		else if (hard_reset)
			flags_q <= SDT_RST_REG;
		else
			flags_q <= (flags_q & ~flag_clr) | flag_set;
	end

	assign low_compare_irq = flags_q[SDT_FLAG_LOW_CMP_LSB +: CHANNELS]
		& irq_en_q[SDT_FLAG_LOW_CMP_LSB +: CHANNELS];
	assign high_underflow_irq = flags_q[SDT_FLAG_HIGH_UNF] && irq_en_q[SDT_FLAG_HIGH_UNF];
	assign low_underflow_irq = flags_q[SDT_FLAG_LOW_UNF] && irq_en_q[SDT_FLAG_LOW_UNF];

	////////////////////////////////////////////////////////////////////////
	// waveform outputs: pwm high while counter is below compare

	logic [2*CHANNELS-1:0] wave_q;
	logic [2*CHANNELS-1:0] oe_q;

	generate
		for (c = 0; c < CHANNELS; c++)
		begin : g_wave
			always_ff @(posedge hclk or negedge hresetn)
			begin
				if (!hresetn)
				begin
					wave_q[c] <= 1'b0;
					wave_q[CHANNELS+c] <= 1'b0;
				end
				else if (!enabled)
				begin
					wave_q[c] <= out_value_q[SDT_LOW_CH_LSB+c];
					wave_q[CHANNELS+c] <= out_value_q[SDT_HIGH_CH_LSB+c];
				end
				else
				begin
					wave_q[c] <= low_cnt < low_cmp_q[c];
					wave_q[CHANNELS+c] <= high_cnt < high_cmp_q[c];
				end
			end

			always_ff @(posedge hclk or negedge hresetn)
			begin
				if (!hresetn)
					oe_q[c] <= 1'b0;
				else
					oe_q[c] <= out_en_q[SDT_LOW_CH_LSB+c];
			end

			always_ff @(posedge hclk or negedge hresetn)
			begin
				if (!hresetn)
					oe_q[CHANNELS+c] <= 1'b0;
				else
					oe_q[CHANNELS+c] <= out_en_q[SDT_HIGH_CH_LSB+c];
			end
		end
	endgenerate

	assign waveform_out_pin = wave_q;
	assign waveform_out_oe = oe_q;

	////////////////////////////////////////////////////////////////////////
	// read mux

	always_comb
	begin
		rdata = 8'h00;
		case (acc_idx_q)
			SDT_IDX_RUN_CTL: rdata = run_ctl_q;
			SDT_IDX_OUT_EN: rdata = out_en_q;
			SDT_IDX_OUT_VALUE: rdata = out_value_q;
			SDT_IDX_SPLIT_SEL: rdata = split_sel_q;
			SDT_IDX_CMD_CLR, SDT_IDX_CMD_SET: rdata = status_q & SDT_STATUS_MASK;
			SDT_IDX_IRQ_EN: rdata = irq_en_q;
			SDT_IDX_IRQ_FLAGS: rdata = flags_q;
			SDT_IDX_DBG: rdata = dbg_q;
			SDT_IDX_LOW_CNT: rdata = low_cnt;
			SDT_IDX_HIGH_CNT: rdata = high_cnt;
			SDT_IDX_LOW_TOP: rdata = low_top_q;
			SDT_IDX_HIGH_TOP: rdata = high_top_q;
			default:
			begin
				for (int k = 0; k < CHANNELS; k++)
				begin
					if (acc_idx_q == SDT_IDX_LOW_CMP0 + 6'(k * SDT_IDX_CMP_STEP))
						rdata = low_cmp_q[k];
					if (acc_idx_q == SDT_IDX_HIGH_CMP0 + 6'(k * SDT_IDX_CMP_STEP))
						rdata = high_cmp_q[k];
				end
			end
		endcase
	end

endmodule // sdt_timer

// ==== pkg/sdt_pkg.sv ====
package sdt_pkg;

	// register indices; byte address is four times the index
	localparam logic [5:0] SDT_IDX_RUN_CTL = 6'h00;
	localparam logic [5:0] SDT_IDX_OUT_EN = 6'h01;
	localparam logic [5:0] SDT_IDX_OUT_VALUE = 6'h02;
	localparam logic [5:0] SDT_IDX_SPLIT_SEL = 6'h03;
	localparam logic [5:0] SDT_IDX_CMD_CLR = 6'h04;
	localparam logic [5:0] SDT_IDX_CMD_SET = 6'h05;
	localparam logic [5:0] SDT_IDX_IRQ_EN = 6'h0a;
	localparam logic [5:0] SDT_IDX_IRQ_FLAGS = 6'h0b;
	localparam logic [5:0] SDT_IDX_DBG = 6'h0e;
	localparam logic [5:0] SDT_IDX_LOW_CNT = 6'h20;
	localparam logic [5:0] SDT_IDX_HIGH_CNT = 6'h21;
	localparam logic [5:0] SDT_IDX_LOW_TOP = 6'h26;
	localparam logic [5:0] SDT_IDX_HIGH_TOP = 6'h27;
	localparam logic [5:0] SDT_IDX_LOW_CMP0 = 6'h28;
	localparam logic [5:0] SDT_IDX_HIGH_CMP0 = 6'h29;
	localparam logic [5:0] SDT_IDX_CMP_STEP = 6'h02;

	// field positions
	localparam int SDT_RUN_ENABLE_BIT = 0;
	localparam int SDT_CLKSEL_LSB = 1;
	localparam int SDT_LOW_CH_LSB = 0;
	localparam int SDT_HIGH_CH_LSB = 4;
	localparam int SDT_SPLIT_BIT = 0;
	localparam int SDT_CMD_LSB = 2;
	localparam int SDT_DBG_RUN_BIT = 0;
	localparam int SDT_FLAG_LOW_UNF = 0;
	localparam int SDT_FLAG_HIGH_UNF = 1;
	localparam int SDT_FLAG_LOW_CMP_LSB = 4;
	localparam logic [7:0] SDT_STATUS_MASK = 8'h03;
	localparam int SDT_STATUS_HOLD_BIT = 0;

	// reset values
	localparam logic [7:0] SDT_RST_REG = 8'h00;
	localparam logic [7:0] SDT_RST_TOP = 8'h00;

	typedef enum logic [1:0] {
		SDT_CMD_NONE = 2'h0,
		SDT_CMD_UPDATE = 2'h1,
		SDT_CMD_RESTART = 2'h2,
		SDT_CMD_HARD_RESET = 2'h3
	} sdt_cmd_type;

endpackage
